// ---- pser_host_model.sv ----
// host model: two-wire bus master issuing register reads and writes
`timescale 1ns/1ps
`default_nettype none
module pser_host_model #(
	parameter logic [6:0] DEV_ADDR = 7'h10
) (
	// clock
	input wire logic i_clk_sys,
	// bus lines
	input wire logic i_sda,
	output logic o_scl,
	output logic o_sda_low
);
	localparam int HALF = 10;
	// clock line idles high between frames
	initial begin
		o_scl = 1'b1;
		o_sda_low = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge i_clk_sys);
	endtask
	// data moves only with the clock low; short hold avoids a false start
	task automatic xfer_bit(input logic b, output logic s);
		o_sda_low <= !b;
		tick(HALF);
		o_scl <= 1'b1;
		tick(HALF / 2);
		s = i_sda;
		tick(HALF / 2);
		o_scl <= 1'b0;
		tick(2);
	endtask
	task automatic start_cond();
		o_sda_low <= 1'b0;
		tick(2);
		o_scl <= 1'b1;
		tick(HALF);
		o_sda_low <= 1'b1;
		tick(HALF);
		o_scl <= 1'b0;
		tick(2);
	endtask
	task automatic stop_cond();
		o_sda_low <= 1'b1;
		tick(HALF);
		o_scl <= 1'b1;
		tick(HALF);
		o_sda_low <= 1'b0;
		tick(HALF);
	endtask
	task automatic send_byte(input logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			xfer_bit(d[i], s);
		end
		xfer_bit(1'b1, s);
	endtask
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		start_cond();
		send_byte({DEV_ADDR, 1'b0});
		send_byte(a);
		send_byte(d);
		stop_cond();
	endtask
	task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
		logic s;
		start_cond();
		send_byte({DEV_ADDR, 1'b0});
		send_byte(a);
		start_cond();
		send_byte({DEV_ADDR, 1'b1});
		for (int i = 7; i >= 0; i--) begin
			xfer_bit(1'b1, d[i]);
		end
		xfer_bit(1'b1, s);
		stop_cond();
	endtask
endmodule
`default_nettype wire

// ---- pser_i2c_slave.sv ----
// module: serial two-wire slave turning bus frames into register reads and writes
`timescale 1ns/1ps
`default_nettype none
module pser_i2c_slave #(
	parameter logic [6:0] DEV_ADDR = pser_pkg::DEV_ADDR_DEFAULT
) (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst_b,
	// synchronised bus lines
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda_oe,
	// register side
	pser_regbus_if.slave_side bus
);
	typedef enum logic [2:0] {
		PSER_IDLE, PSER_DEVADDR, PSER_ACK, PSER_REGADDR, PSER_WDATA, PSER_RDATA, PSER_RACK
	} pser_i2c_state_t;

	pser_i2c_state_t state;
	pser_i2c_state_t after_ack;
	logic scl_d;
	logic sda_d;
	logic [7:0] shift;
	logic [3:0] bitcnt;
	logic have_reg;
	logic scl_rise;
	logic scl_fall;
	logic start_cond;
	logic stop_cond;

	assign scl_rise = i_scl && !scl_d;
	assign scl_fall = !i_scl && scl_d;
	assign start_cond = i_scl && scl_d && sda_d && !i_sda;
	assign stop_cond = i_scl && scl_d && !sda_d && i_sda;

	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_d <= i_scl;
			sda_d <= i_sda;
		end
	end

	// ======================================================
	// frame sequencing; only reads advance the register address, on a master acknowledge
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state <= PSER_IDLE;
			after_ack <= PSER_IDLE;
			shift <= 8'h00;
			bitcnt <= 4'h0;
			have_reg <= 1'b0;
			o_sda_oe <= 1'b0;
			bus.addr <= 8'h00;
			bus.wdata <= 8'h00;
			bus.wr <= 1'b0;
			bus.rd <= 1'b0;
		end else begin
			bus.wr <= 1'b0;
			bus.rd <= 1'b0;
			if (start_cond) begin
				state <= PSER_DEVADDR;
				bitcnt <= 4'h0;
				have_reg <= 1'b0;
				o_sda_oe <= 1'b0;
			end else if (stop_cond) begin
				state <= PSER_IDLE;
				o_sda_oe <= 1'b0;
			end else begin
				unique case (state)
					PSER_IDLE: begin
						o_sda_oe <= 1'b0;
					end
					PSER_DEVADDR, PSER_REGADDR, PSER_WDATA: begin
						if (scl_rise) begin
							shift <= {shift[6:0], i_sda};
							bitcnt <= bitcnt + 4'h1;
						end else if (scl_fall && bitcnt == 4'h8) begin
							bitcnt <= 4'h0;
							if (state == PSER_DEVADDR) begin
								if (shift[7:1] != DEV_ADDR) begin
									state <= PSER_IDLE;
								end else if (shift[0]) begin
									o_sda_oe <= 1'b1;
									state <= PSER_ACK;
									after_ack <= PSER_RDATA;
								end else begin
									o_sda_oe <= 1'b1;
									state <= PSER_ACK;
									after_ack <= have_reg ? PSER_WDATA : PSER_REGADDR;
								end
							end else if (state == PSER_REGADDR) begin
								bus.addr <= shift;
								have_reg <= 1'b1;
								o_sda_oe <= 1'b1;
								state <= PSER_ACK;
								after_ack <= PSER_WDATA;
							end else begin
								bus.wdata <= shift;
								bus.wr <= 1'b1;
								o_sda_oe <= 1'b1;
								state <= PSER_ACK;
								after_ack <= PSER_WDATA;
							end
						end
					end
					PSER_ACK: begin
						if (scl_fall) begin
							state <= after_ack;
							o_sda_oe <= 1'b0;
							// strobe in the same cycle the byte is taken, so a read-clear
							// register hands over what it held before clearing
							if (after_ack == PSER_RDATA) begin
								bus.rd <= 1'b1;
								bitcnt <= 4'h0;
							end
						end
					end
					PSER_RDATA: begin
						if (bitcnt == 4'h0) begin
							shift <= bus.rdata;
							o_sda_oe <= !bus.rdata[7];
							bitcnt <= 4'h1;
						end else if (scl_fall) begin
							if (bitcnt == 4'h8) begin
								o_sda_oe <= 1'b0;
								bitcnt <= 4'h0;
								state <= PSER_RACK;
							end else begin
								o_sda_oe <= !shift[3'(7 - bitcnt)];
								bitcnt <= bitcnt + 4'h1;
							end
						end
					end
					PSER_RACK: begin
						if (scl_rise) begin
							if (i_sda) begin
								state <= PSER_IDLE;
							end else begin
								bus.addr <= bus.addr + 8'h01;
								after_ack <= PSER_RDATA;
								state <= PSER_ACK;
							end
						end
					end
					default: state <= PSER_IDLE;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// ---- pser_pkg.sv ----
// package: register map, field positions and reset values of the regulator register bank
package pser_pkg;
	// ======================================================
	// register addresses
	localparam logic [7:0] ADDR_PGOOD_ACK = 8'h00;
	localparam logic [7:0] ADDR_POWER_PIN_SENSE = 8'h02;
	localparam logic [7:0] ADDR_FAULT_SENSE = 8'h03;
	localparam logic [7:0] ADDR_RESET_CONTROL = 8'h10;
	localparam logic [7:0] ADDR_PRODUCT_IDENT = 8'h11;
	localparam logic [7:0] ADDR_REV_FEATURE = 8'h12;
	localparam logic [7:0] ADDR_ENABLE_MODE = 8'h14;
	// ======================================================
	// reset control fields
	localparam int RST_FORCE_BIT = 7;
	localparam int RST_FLAG_BIT = 4;
	localparam logic [7:0] RESET_CONTROL_DEFAULT = 8'h10;
	localparam logic [7:0] RESET_CONTROL_WMASK = 8'h13;
	// ======================================================
	// enable/mode fields: mode D0/D2, enable D1/D3/D6/D7
	localparam logic [7:0] ENABLE_MODE_WMASK = 8'hCF;
	localparam int BUCK1_PWM_BIT = 0;
	localparam int BUCK1_ON_BIT = 1;
	localparam int BUCK2_PWM_BIT = 2;
	localparam int BUCK2_ON_BIT = 3;
	localparam int LINREG3_ON_BIT = 6;
	localparam int LINREG4_ON_BIT = 7;
	// power-good bits inside the first sense register
	localparam logic [7:0] PGOOD_MASK = 8'h33;
	localparam int FAULT_SPARE_BIT = 3;
	// ======================================================
	typedef enum logic [1:0] {
		PSER_RESTART_RELOAD = 2'h0,
		PSER_RESTART_KEEP = 2'h1,
		PSER_RESTART_NONE = 2'h2,
		PSER_RESTART_UNDEF = 2'h3
	} pser_restart_policy_t;
	// ======================================================
	// serial slave
	localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h10;
	localparam int SYNC_STAGES = 2;
endpackage

// ---- pser_regbank.sv ----
// module: regulator sense, restart policy, identification and enable register bank
`timescale 1ns/1ps
`default_nettype none
// Function
// R1 - power-good bits at D0,D1,D4,D5 of 0x02 show output in range
// R2 - enable-pin bits at D2,D3,D6,D7 mirror the live pin levels
// R3 - overcurrent bits at D0,D1,D4,D5 of 0x03 show current over limit
// R4 - D2 of 0x03 shows input supply below lockout threshold
// R5 - D6 of 0x03 shows junction above thermal warning limit
// R6 - D7 of 0x03 shows thermal shutdown; D3 always reads zero
// R7 - restart policy 00: after shutdown reload defaults, then power up again
// R8 - restart policy 01: after shutdown power up again keeping registers
// R9 - restart policy 10: stay off after shutdown; 11 undefined, host avoids it
// R10 - defaults-loaded flag set on every reload; host clears it by writing 0
// R11 - writing 1 to force bit D7 reloads all registers except the power-good flags at 0x00; reads back 0
// R12 - read-only 8-bit product identification at 0x11
// R13 - 0x12 holds revision in upper nibble, feature variant in lower
// R14 - mode bits D0,D2: 0 auto switching, 1 forced pulse-width (default)
// R15 - enable bits D1,D3,D6,D7 turn each regulator on or off
// R16 - restart policy sits at bits 1:0; register resets to 0x10
// R17 - spare bits read zero and writes to them do nothing
// R18 - power-good changes latch flags at 0x00, cleared by reading it
module pser_regbank #(
	parameter logic [7:0] PRODUCT_ID = 8'hA5, // arbitrary value
	parameter logic [3:0] SILICON_REV = 4'h7, // arbitrary value
	parameter logic [3:0] FEATURE_VAR = 4'h5, // arbitrary value
	parameter logic [7:0] ENABLE_DEFAULT = 8'h05,
	parameter logic [6:0] DEV_ADDR = pser_pkg::DEV_ADDR_DEFAULT
) (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst_b,
	// serial bus pins
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda_out,
	output logic o_sda_oe,
	// analog status, pins and sensors
	input wire logic [3:0] i_pgood,
	input wire logic [3:0] i_pin_level,
	input wire logic [3:0] i_overcurrent,
	input wire logic i_undervoltage,
	input wire logic i_thermal_warning,
	input wire logic i_thermal_shutdown,
	// regulator controls
	output logic [3:0] o_reg_on,
	output logic o_buck1_pwm_force,
	output logic o_buck2_pwm_force,
	output logic o_power_up_start,
	output logic o_defaults_loaded_flag
);
	// ======================================================
	// synchronisers
	logic [1:0] scl_sda_sync;
	logic [3:0] pgood;
	logic [3:0] pin_level;
	logic [3:0] overcurrent;
	logic [2:0] misc;
	logic sda_oe_int;

	pser_sync #(.WIDTH(2), .INIT(2'h3)) u_sync_bus (
		.i_clk_sys(i_clk_sys),
		.i_rst_b(i_rst_b),
		.i_async({i_scl, i_sda}),
		.o_sync(scl_sda_sync)
	);
	pser_sync #(.WIDTH(15), .INIT(15'h0000)) u_sync_sense (
		.i_clk_sys(i_clk_sys),
		.i_rst_b(i_rst_b),
		.i_async({i_pgood, i_pin_level, i_overcurrent, i_undervoltage,
			i_thermal_warning, i_thermal_shutdown}),
		.o_sync({pgood, pin_level, overcurrent, misc})
	);

	pser_regbus_if rbus ();

	pser_i2c_slave #(.DEV_ADDR(DEV_ADDR)) u_slave (
		.i_clk_sys(i_clk_sys),
		.i_rst_b(i_rst_b),
		.i_scl(scl_sda_sync[1]),
		.i_sda(scl_sda_sync[0]),
		.o_sda_oe(sda_oe_int),
		.bus(rbus.slave_side)
	);

	// ======================================================
	// sense views
	logic [7:0] power_and_pin_sense;
	logic [7:0] fault_sense;
	assign power_and_pin_sense = {pin_level[3], pin_level[2], pgood[3], pgood[2], // R1 R2
		pin_level[1], pin_level[0], pgood[1], pgood[0]}; // R1 R2
	assign fault_sense = {misc[0], misc[1], overcurrent[3], overcurrent[2], // R3 R5 R6
		1'b0, misc[2], overcurrent[1], overcurrent[0]}; // R3 R4 R6

	// ======================================================
	// writable registers and reload
	logic [1:0] restart_policy;
	logic defaults_loaded_flag;
	logic [7:0] regulator_enable_mode;
	logic shutdown_d;
	logic shutdown_fall;
	logic shutdown_rise;
	logic force_defaults;
	logic reload;
	logic wr_reset;
	logic wr_enable;

	assign wr_reset = rbus.wr && rbus.addr == pser_pkg::ADDR_RESET_CONTROL;
	assign wr_enable = rbus.wr && rbus.addr == pser_pkg::ADDR_ENABLE_MODE;
	assign force_defaults = wr_reset && rbus.wdata[pser_pkg::RST_FORCE_BIT]; // R11
	assign shutdown_rise = misc[0] && !shutdown_d;
	assign shutdown_fall = !misc[0] && shutdown_d;
	// only the reload policy brings the registers back after a shutdown
	assign reload = force_defaults || (shutdown_fall
		&& restart_policy == pser_pkg::PSER_RESTART_RELOAD); // R7

	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			shutdown_d <= 1'b0;
		end else begin
			shutdown_d <= misc[0];
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			restart_policy <= pser_pkg::RESET_CONTROL_DEFAULT[1:0]; // R16
			defaults_loaded_flag <= pser_pkg::RESET_CONTROL_DEFAULT[pser_pkg::RST_FLAG_BIT];
		end else if (reload) begin
			restart_policy <= pser_pkg::RESET_CONTROL_DEFAULT[1:0]; // R11 R7
			defaults_loaded_flag <= 1'b1; // R10
		end else if (wr_reset) begin
			restart_policy <= rbus.wdata[1:0]; // R16 R9
			defaults_loaded_flag <= rbus.wdata[pser_pkg::RST_FLAG_BIT]; // R10
		end
	end

	// the shutdown pin forces regulators off at the output stage, not here
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			regulator_enable_mode <= ENABLE_DEFAULT & pser_pkg::ENABLE_MODE_WMASK;
		end else if (reload) begin
			regulator_enable_mode <= ENABLE_DEFAULT & pser_pkg::ENABLE_MODE_WMASK; // R11
		end else if (wr_enable) begin
			regulator_enable_mode <= rbus.wdata & pser_pkg::ENABLE_MODE_WMASK; // R17
		end
	end

	// ======================================================
	// latched power-good change flags, cleared on read; a change wins over the clear
	logic [3:0] pgood_d;
	logic [7:0] pgood_events;
	logic [7:0] pgood_change;
	assign pgood_change = {2'b00, pgood[3:2] ^ pgood_d[3:2], 2'b00, pgood[1:0] ^ pgood_d[1:0]};

	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			pgood_d <= 4'h0;
			pgood_events <= 8'h00;
		end else begin
			pgood_d <= pgood;
			if (rbus.rd && rbus.addr == pser_pkg::ADDR_PGOOD_ACK) begin
				pgood_events <= pgood_change; // R18
			end else begin
				pgood_events <= pgood_events | pgood_change; // R18
			end
		end
	end

	// ======================================================
	// read mux; unmapped addresses read zero
	always_comb begin
		unique case (rbus.addr)
			pser_pkg::ADDR_PGOOD_ACK: rbus.rdata = pgood_events;
			pser_pkg::ADDR_POWER_PIN_SENSE: rbus.rdata = power_and_pin_sense;
			pser_pkg::ADDR_FAULT_SENSE: rbus.rdata = fault_sense;
			pser_pkg::ADDR_RESET_CONTROL: begin
				rbus.rdata = {3'b000, defaults_loaded_flag, 2'b00, restart_policy}; // R17
			end
			pser_pkg::ADDR_PRODUCT_IDENT: rbus.rdata = PRODUCT_ID; // R12
			pser_pkg::ADDR_REV_FEATURE: rbus.rdata = {SILICON_REV, FEATURE_VAR}; // R13
			pser_pkg::ADDR_ENABLE_MODE: rbus.rdata = regulator_enable_mode;
			default: rbus.rdata = 8'h00;
		endcase
	end

	// ======================================================
	// outputs
	logic shutdown_latched;
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			shutdown_latched <= 1'b0;
		end else if (shutdown_rise) begin
			shutdown_latched <= 1'b1;
		end else if (shutdown_fall && restart_policy != pser_pkg::PSER_RESTART_NONE) begin
			shutdown_latched <= 1'b0; // R8 R9
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_reg_on <= 4'h0;
			o_buck1_pwm_force <= 1'b0;
			o_buck2_pwm_force <= 1'b0;
			o_power_up_start <= 1'b0;
			o_defaults_loaded_flag <= 1'b0;
			o_sda_out <= 1'b0;
			o_sda_oe <= 1'b0;
		end else begin
			o_reg_on <= shutdown_latched ? 4'h0 : {
				regulator_enable_mode[pser_pkg::LINREG4_ON_BIT],
				regulator_enable_mode[pser_pkg::LINREG3_ON_BIT],
				regulator_enable_mode[pser_pkg::BUCK2_ON_BIT],
				regulator_enable_mode[pser_pkg::BUCK1_ON_BIT]}; // R15
			o_buck1_pwm_force <= regulator_enable_mode[pser_pkg::BUCK1_PWM_BIT]; // R14
			o_buck2_pwm_force <= regulator_enable_mode[pser_pkg::BUCK2_PWM_BIT]; // R14
			o_power_up_start <= shutdown_fall
				&& restart_policy != pser_pkg::PSER_RESTART_NONE; // R7 R8 R9
			o_defaults_loaded_flag <= defaults_loaded_flag;
			o_sda_out <= 1'b0;
			o_sda_oe <= sda_oe_int;
		end
	end
endmodule
`default_nettype wire

// ---- pser_regbank_assertions.sv ----
// checker: port-level properties of the regulator register bank
`timescale 1ns/1ps
`default_nettype none
module pser_regbank_assertions (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst_b,
	// watched inputs
	input wire logic i_scl,
	input wire logic i_thermal_shutdown,
	// watched outputs
	input wire logic [3:0] o_reg_on,
	input wire logic o_buck1_pwm_force,
	input wire logic o_buck2_pwm_force,
	input wire logic o_power_up_start,
	input wire logic o_defaults_loaded_flag
);
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_b);
	// ======================================================
	// cycles since shutdown input was last high, saturating
	logic [7:0] since_trip;
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			since_trip <= 8'hFF;
		end else if (i_thermal_shutdown) begin
			since_trip <= 8'h00;
		end else if (since_trip != 8'hFF) begin
			since_trip <= since_trip + 8'h01;
		end
	end
	sequence s_trip_held;
		i_thermal_shutdown [*6];
	endsequence
	sequence s_trip_short;
		i_thermal_shutdown [*4];
	endsequence
	// ======================================================
	// properties
	a_pulse_one_cycle: assert property (o_power_up_start |=> !o_power_up_start)
		else $error("restart pulse longer than one cycle");
	a_restart_after_trip: assert property (o_power_up_start |-> since_trip inside {[8'h01:8'h0C]})
		else $error("restart pulse without a shutdown just ended");
	a_trip_forces_off: assert property (s_trip_held |-> o_reg_on == 4'h0)
		else $error("regulator on during shutdown");
	a_no_pulse_trip: assert property (s_trip_short |-> !o_power_up_start)
		else $error("restart pulse while shutdown held");
	a_flag_clear_write: assert property ($fell(o_defaults_loaded_flag) |-> !$past(i_scl, 2))
		else $error("defaults flag cleared outside a bus write");
	a_pwm1_fall_write: assert property ($fell(o_buck1_pwm_force) |-> !$past(i_scl, 2))
		else $error("buck1 mode left forced outside a bus write");
	a_pwm2_fall_write: assert property ($fell(o_buck2_pwm_force) |-> !$past(i_scl, 2))
		else $error("buck2 mode left forced outside a bus write");
	a_enable_rise_cause: assert property ((o_reg_on & ~$past(o_reg_on)) != 4'h0
		|-> !$past(i_scl, 2) || since_trip < 8'h10)
		else $error("regulator switched on without write or restart");
endmodule
bind pser_regbank pser_regbank_assertions u_chk (
	.i_clk_sys(i_clk_sys),
	.i_rst_b(i_rst_b),
	.i_scl(i_scl),
	.i_thermal_shutdown(i_thermal_shutdown),
	.o_reg_on(o_reg_on),
	.o_buck1_pwm_force(o_buck1_pwm_force),
	.o_buck2_pwm_force(o_buck2_pwm_force),
	.o_power_up_start(o_power_up_start),
	.o_defaults_loaded_flag(o_defaults_loaded_flag)
);
`default_nettype wire

// ---- pser_regbank_tb.sv ----
// testbench: register bank checked through serial register reads and writes
`timescale 1ns/1ps
`default_nettype none
module pser_regbank_tb;
	localparam logic [7:0] PROD_CODE = 8'h5A; // arbitrary value
	localparam logic [3:0] REV = 4'h9; // arbitrary value
	localparam logic [3:0] FEAT = 4'h6; // arbitrary value
	localparam logic [7:0] A_RST = pser_pkg::ADDR_RESET_CONTROL;
	localparam logic [7:0] A_EN = pser_pkg::ADDR_ENABLE_MODE;
	logic i_clk_sys;
	logic i_rst_b;
	wire logic scl;
	wire logic host_low;
	wire logic sda;
	logic sda_out;
	logic sda_oe;
	logic [3:0] pgood;
	logic [3:0] pin;
	logic [3:0] oc;
	logic uv;
	logic tw;
	logic therm_trip;
	logic [3:0] reg_on;
	logic pwm1;
	logic pwm2;
	logic up_start;
	logic flag;
	int err_total;
	int cmp_count;
	int pulses = 0;
	logic [7:0] rv;
	// pull-up: low while the host pulls or the device drives its output level
	assign sda = !host_low && (sda_oe ? sda_out : 1'b1);
	pser_regbank #(.PRODUCT_ID(PROD_CODE), .SILICON_REV(REV), .FEATURE_VAR(FEAT)) u_dut (
		.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_scl(scl), .i_sda(sda),
		.o_sda_out(sda_out), .o_sda_oe(sda_oe), .i_pgood(pgood), .i_pin_level(pin),
		.i_overcurrent(oc), .i_undervoltage(uv), .i_thermal_warning(tw),
		.i_thermal_shutdown(therm_trip), .o_reg_on(reg_on), .o_buck1_pwm_force(pwm1),
		.o_buck2_pwm_force(pwm2), .o_power_up_start(up_start), .o_defaults_loaded_flag(flag));
	pser_host_model u_host (.i_clk_sys(i_clk_sys), .i_sda(sda), .o_scl(scl), .o_sda_low(host_low));
	// ======================================================
	// clock, counters and closing report
	initial begin
		i_clk_sys = 1'b0;
		forever #2.5 i_clk_sys = ~i_clk_sys;
	end
	always @(posedge i_clk_sys) begin
		if (up_start === 1'b1) begin
			pulses <= pulses + 1;
		end
	end
	task automatic finish_test();
		if (err_total == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		u_host.read_reg(a, rv);
		chk($sformatf("register %h", a), rv, exp);
	endtask
	task automatic do_reset();
		i_rst_b <= 1'b0;
		repeat (2) @(posedge i_clk_sys);
		i_rst_b <= 1'b1;
		repeat (4) @(posedge i_clk_sys);
	endtask
	initial begin
		repeat (90000) @(posedge i_clk_sys);
		err_total++;
		finish_test();
	end
	// ======================================================
	// main sequence
	initial begin
		static logic [3:0] pats [3] = '{4'h5, 4'hA, 4'h0};
		static logic [7:0] wv [4] = '{8'hFF, 8'h0A, 8'hC0, 8'h05};
		logic [3:0] p;
		logic [3:0] d;
		logic [3:0] prev;
		int n;
		{i_rst_b, pgood, pin, oc, uv, tw, therm_trip} = '0;
		{err_total, cmp_count} = '0;
		do_reset();
		chk("defaults flag", {7'h0, flag}, 8'h01);
		chk("mode outputs", {6'h0, pwm2, pwm1}, 8'h03);
		rd_chk(A_RST, 8'h10);
		rd_chk(A_EN, 8'h05);
		rd_chk(pser_pkg::ADDR_PRODUCT_IDENT, PROD_CODE);
		u_host.write_reg(pser_pkg::ADDR_PRODUCT_IDENT, 8'hFF);
		rd_chk(pser_pkg::ADDR_PRODUCT_IDENT, PROD_CODE);
		rd_chk(pser_pkg::ADDR_REV_FEATURE, {REV, FEAT});
		rd_chk(8'h13, 8'h00);
		prev = 4'h0;
		foreach (pats[i]) begin
			p = pats[i];
			d = p ^ prev;
			@(posedge i_clk_sys);
			pgood <= p;
			pin <= ~p;
			oc <= p;
			uv <= p[0];
			tw <= p[1];
			rd_chk(pser_pkg::ADDR_POWER_PIN_SENSE, {~p[3:2], p[3:2], ~p[1:0], p[1:0]});
			rd_chk(pser_pkg::ADDR_FAULT_SENSE, {1'b0, p[1], p[3:2], 1'b0, p[0], p[1:0]});
			rd_chk(pser_pkg::ADDR_PGOOD_ACK, {2'h0, d[3:2], 2'h0, d[1:0]});
			rd_chk(pser_pkg::ADDR_PGOOD_ACK, 8'h00);
			prev = p;
		end
		foreach (wv[i]) begin
			u_host.write_reg(A_EN, wv[i]);
			rd_chk(A_EN, wv[i] & 8'hCF);
			chk("enables", {4'h0, reg_on}, {4'h0, wv[i][7:6], wv[i][3], wv[i][1]});
			chk("mode outputs", {6'h0, pwm2, pwm1}, {6'h0, wv[i][2], wv[i][0]});
		end
		// host clears the flag, touching spare bits as well
		u_host.write_reg(A_RST, 8'h6C);
		chk("defaults flag", {7'h0, flag}, 8'h00);
		rd_chk(A_RST, 8'h00);
		u_host.write_reg(A_EN, 8'hCA);
		u_host.write_reg(A_RST, 8'h80);
		chk("defaults flag", {7'h0, flag}, 8'h01);
		rd_chk(A_RST, 8'h10);
		rd_chk(A_EN, 8'h05);
		// policy 11 is never written by the host
		for (int k = 0; k < 3; k++) begin
			u_host.write_reg(A_RST, 8'(k));
			u_host.write_reg(A_EN, 8'hCA);
			n = pulses;
			@(posedge i_clk_sys);
			therm_trip <= 1'b1;
			rd_chk(pser_pkg::ADDR_FAULT_SENSE, 8'h80);
			chk("enables", {4'h0, reg_on}, 8'h00);
			@(posedge i_clk_sys);
			therm_trip <= 1'b0;
			repeat (20) @(posedge i_clk_sys);
			chk("restarts", 8'(pulses - n), (k == 2) ? 8'h00 : 8'h01);
			chk("defaults flag", {7'h0, flag}, (k == 0) ? 8'h01 : 8'h00);
			chk("enables", {4'h0, reg_on}, (k == 1) ? 8'h0F : 8'h00);
			rd_chk(A_EN, (k == 0) ? 8'h05 : 8'hCA);
		end
		do_reset();
		rd_chk(A_RST, 8'h10);
		finish_test();
	end
endmodule
`default_nettype wire

// ---- pser_regbus_if.sv ----
// interface: byte-wide register access between serial slave and register bank
`timescale 1ns/1ps
`default_nettype none
interface pser_regbus_if;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic wr;
	logic rd;
	logic [7:0] rdata;
	modport slave_side (output addr, output wdata, output wr, output rd, input rdata);
	modport bank_side (input addr, input wdata, input wr, input rd, output rdata);
endinterface
`default_nettype wire

// ---- pser_sync.sv ----
// module: two-flop synchroniser for a bus of pin levels
`timescale 1ns/1ps
`default_nettype none
module pser_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst_b,
	// levels
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);
	logic [WIDTH-1:0] meta;

	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			meta <= INIT;
			o_sync <= INIT;
		end else begin
			meta <= i_async;
			o_sync <= meta;
		end
	end
endmodule
`default_nettype wire
